// ### logic/flow_control.sv
// Purpose: program-flow control of a dsp core
// Assumes: one instruction completes per cycle when instr_valid is high
// Notes: delayed branches, block and single repeat, register calls
// Notes on behaviour
// - a delayed branch runs the next three instructions before jumping, no flush.
// - a conditional delayed branch uses flags left by the preceding instruction.
// - block repeat and single repeat both loop with no overhead cycles.
// - loops run from start address, end address and counter registers.
// - repeats load start and end themselves; software loads the counter first.
// - a counter of N at entry gives N+1 passes.
// - at the end of each pass the pc loops back to start or exits.
// - only one set of loop registers exists; software saves them to nest.
// - single repeat fetches its instruction once, freeing the buses.
// - single repeat blocks interrupts; block repeat stays interruptible.
// - a register call jumps to the target address carried in the instruction.
`timescale 1ns/1ps
`default_nettype none
module flow_control (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic instr_valid,
	input wire flow_ctrl_pkg::instr_type instr,
	input wire logic [flow_ctrl_pkg::REG_AW-1:0] reg_addr,
	input wire logic [flow_ctrl_pkg::ADDR_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [flow_ctrl_pkg::ADDR_W-1:0] reg_rdata,
	output logic [flow_ctrl_pkg::ADDR_W-1:0] pc,
	output logic fetch_en,
	output logic int_allowed,
	output logic call_push,
	output logic [flow_ctrl_pkg::ADDR_W-1:0] call_return
);
	typedef enum logic [1:0] {
		mode_idle,
		mode_block,
		mode_single
	} loop_mode_type;

	flow_ctrl_pkg::reg_req_type req;
	logic [flow_ctrl_pkg::ADDR_W-1:0] pc_q, pc_d;
	logic [flow_ctrl_pkg::ADDR_W-1:0] start_q, start_d;
	logic [flow_ctrl_pkg::ADDR_W-1:0] end_q, end_d;
	logic [flow_ctrl_pkg::ADDR_W-1:0] count_q, count_d;
	loop_mode_type mode_q, mode_d;
	logic flag_q, flag_d;
	logic slot_busy_q, slot_busy_d;
	logic [1:0] slot_q, slot_d;
	logic [flow_ctrl_pkg::ADDR_W-1:0] br_target_q, br_target_d;
	logic [flow_ctrl_pkg::ADDR_W-1:0] rdata_q, rdata_d;
	logic push_q, push_d;
	logic [flow_ctrl_pkg::ADDR_W-1:0] ret_q, ret_d;
	logic at_end, take_back;
	logic [flow_ctrl_pkg::ADDR_W-1:0] count_next;
	logic [flow_ctrl_pkg::ADDR_W-1:0] pc_inc;
	logic [flow_ctrl_pkg::ADDR_W-1:0] status_word;
	// decoded strobes of the completing instruction
	logic branch_taken;
	logic call_taken;
	logic block_start;
	logic single_start;
	// registered side outputs
	logic fetch_q, fetch_d;
	logic int_ok_q, int_ok_d;

	assign req.addr = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr = reg_wr;
	assign req.rd = reg_rd;
	assign pc_inc = pc_q + flow_ctrl_pkg::PC_STEP;

	loop_unit u_loop (
		.active(mode_q != mode_idle),
		.pc(pc_q),
		.start_addr(start_q),
		.end_addr(end_q),
		.count(count_q),
		.at_end(at_end),
		.take_back(take_back),
		.count_next(count_next)
	);

	always_comb begin
		status_word = flow_ctrl_pkg::ZERO_WORD;
		status_word[flow_ctrl_pkg::ST_SINGLE_BIT] = (mode_q == mode_single);
		status_word[flow_ctrl_pkg::ST_BLOCK_BIT] = (mode_q == mode_block);
		status_word[flow_ctrl_pkg::ST_DELAY_BIT] = slot_busy_q;
		status_word[flow_ctrl_pkg::ST_INTOK_BIT] = (mode_q != mode_single);
	end

	// decode of the completing instruction
	always_comb begin
		branch_taken = 1'b0;
		call_taken = 1'b0;
		block_start = 1'b0;
		single_start = 1'b0;
		if (instr_valid) begin
			unique case (instr.kind)
				flow_ctrl_pkg::op_delayed_branch: begin
					branch_taken = instr.cond_true && flag_q;
				end
				// block repeat entry
				flow_ctrl_pkg::op_block_repeat: begin
					block_start = 1'b1;
				end
				// single repeat entry
				flow_ctrl_pkg::op_single_repeat: begin
					single_start = 1'b1;
				end
				flow_ctrl_pkg::op_register_call: begin
					call_taken = instr.cond_true && flag_q;
				end
				flow_ctrl_pkg::op_plain: begin
				end
				default: begin
				end
			endcase
		end
	end

	// branch group: flag, delay slots, pc
	always_comb begin
		pc_d = pc_q;
		flag_d = flag_q;
		slot_busy_d = slot_busy_q;
		slot_d = slot_q;
		br_target_d = br_target_q;
		if (instr_valid) begin
			pc_d = pc_inc;
			if (instr.writes_flags) begin
				flag_d = instr.new_flag;
			end
			if (slot_busy_q) begin
				slot_d = slot_q + flow_ctrl_pkg::SLOT_STEP;
				if (slot_q == flow_ctrl_pkg::SLOT_LAST) begin
					pc_d = br_target_q;
					slot_busy_d = 1'b0;
				end
			end
			if (branch_taken) begin
				slot_busy_d = 1'b1;
				slot_d = flow_ctrl_pkg::SLOT_FIRST;
				br_target_d = instr.target;
			end
			if (call_taken) begin
				pc_d = instr.target;
			end
			if (take_back) begin
				pc_d = start_q;
			end
		end
	end

	// the one set of loop registers
	always_comb begin
		start_d = start_q;
		end_d = end_q;
		count_d = count_q;
		mode_d = mode_q;
		if (block_start) begin
			// start and end loaded by hardware
			start_d = pc_inc;
			end_d = instr.target;
			mode_d = mode_block;
		end
		if (single_start) begin
			start_d = pc_inc;
			end_d = pc_inc;
			mode_d = mode_single;
		end
		// loop back or exit at end
		if (instr_valid && at_end) begin
			count_d = count_next;
			if (!take_back) begin
				mode_d = mode_idle;
			end
		end
		if (req.wr) begin
			unique case (req.addr)
				flow_ctrl_pkg::OFS_START: start_d = req.wdata;
				flow_ctrl_pkg::OFS_END: end_d = req.wdata;
				flow_ctrl_pkg::OFS_COUNT: count_d = req.wdata;
				default: begin
				end
			endcase
		end
	end

	// call group: return address and push pulse
	always_comb begin
		push_d = call_taken;
		ret_d = ret_q;
		if (call_taken) begin
			ret_d = pc_inc;
		end
	end

	// side outputs follow the next loop mode
	always_comb begin
		int_ok_d = (mode_d != mode_single);
		// no refetch while single repeat runs
		fetch_d = (mode_d != mode_single);
	end

	always_comb begin
		rdata_d = flow_ctrl_pkg::ZERO_WORD;
		if (req.rd) begin
			unique case (req.addr)
				flow_ctrl_pkg::OFS_START: rdata_d = start_q;
				flow_ctrl_pkg::OFS_END: rdata_d = end_q;
				flow_ctrl_pkg::OFS_COUNT: rdata_d = count_q;
				flow_ctrl_pkg::OFS_STATUS: rdata_d = status_word;
				flow_ctrl_pkg::OFS_PC: rdata_d = pc_q;
				default: rdata_d = flow_ctrl_pkg::ZERO_WORD;
			endcase
		end
	end

	// branch group registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pc_q <= flow_ctrl_pkg::RESET_PC;
			flag_q <= 1'b0;
			slot_busy_q <= 1'b0;
			slot_q <= flow_ctrl_pkg::SLOT_IDLE;
			br_target_q <= flow_ctrl_pkg::ZERO_WORD;
		end else begin
			pc_q <= pc_d;
			flag_q <= flag_d;
			slot_busy_q <= slot_busy_d;
			slot_q <= slot_d;
			br_target_q <= br_target_d;
		end
	end

	// loop registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			start_q <= flow_ctrl_pkg::ZERO_WORD;
			end_q <= flow_ctrl_pkg::ZERO_WORD;
			count_q <= flow_ctrl_pkg::ZERO_WORD;
			mode_q <= mode_idle;
		end else begin
			start_q <= start_d;
			end_q <= end_d;
			count_q <= count_d;
			mode_q <= mode_d;
		end
	end

	// call registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			push_q <= 1'b0;
			ret_q <= flow_ctrl_pkg::ZERO_WORD;
		end else begin
			push_q <= push_d;
			ret_q <= ret_d;
		end
	end

	// side output registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			int_ok_q <= 1'b1;
			fetch_q <= 1'b1;
		end else begin
			int_ok_q <= int_ok_d;
			fetch_q <= fetch_d;
		end
	end

	// read data register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= flow_ctrl_pkg::ZERO_WORD;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign pc = pc_q;
	assign fetch_en = fetch_q;
	assign int_allowed = int_ok_q;
	assign call_push = push_q;
	assign call_return = ret_q;
endmodule : flow_control
`default_nettype wire

// ### logic/flow_ctrl_pkg.sv
// Purpose: shared constants and types for the program-flow control block
// Assumes: 32-bit program addresses, one processor clock
// Notes: register map of the plain software port
`default_nettype none
package flow_ctrl_pkg;
	localparam int ADDR_W = 32;
	localparam int REG_AW = 4;
	localparam int DELAY_SLOTS = 3;
	localparam logic [1:0] SLOT_LAST = 2'h3;
	localparam logic [1:0] SLOT_FIRST = 2'h1;
	localparam logic [1:0] SLOT_STEP = 2'h1;
	localparam logic [1:0] SLOT_IDLE = 2'h0;
	localparam logic [REG_AW-1:0] OFS_START = 4'h0;
	localparam logic [REG_AW-1:0] OFS_END = 4'h1;
	localparam logic [REG_AW-1:0] OFS_COUNT = 4'h2;
	localparam logic [REG_AW-1:0] OFS_STATUS = 4'h3;
	localparam logic [REG_AW-1:0] OFS_PC = 4'h4;
	localparam logic [ADDR_W-1:0] RESET_PC = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] PC_STEP = 32'h0000_0001;
	localparam logic [ADDR_W-1:0] COUNT_STEP = 32'h0000_0001;
	localparam logic [ADDR_W-1:0] ZERO_WORD = 32'h0000_0000;
	localparam int ST_SINGLE_BIT = 0;
	localparam int ST_BLOCK_BIT = 1;
	localparam int ST_DELAY_BIT = 2;
	localparam int ST_INTOK_BIT = 3;

	// one decoded instruction from the fetch stage
	typedef enum logic [2:0] {
		op_plain,
		op_delayed_branch,
		op_block_repeat,
		op_single_repeat,
		op_register_call
	} op_kind_type;

	typedef struct packed {
		op_kind_type kind;
		logic cond_true;
		logic [ADDR_W-1:0] target;
		logic writes_flags;
		logic new_flag;
	} instr_type;

	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [ADDR_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
endpackage : flow_ctrl_pkg
`default_nettype wire

// ### logic/loop_unit.sv
// Purpose: loop-back decision for block and single repeat
// Assumes: counter loaded by software before the repeat starts
// Notes: purely combinational, used once per completed instruction
`timescale 1ns/1ps
`default_nettype none
module loop_unit (
	input wire logic active,
	input wire logic [flow_ctrl_pkg::ADDR_W-1:0] pc,
	input wire logic [flow_ctrl_pkg::ADDR_W-1:0] start_addr,
	input wire logic [flow_ctrl_pkg::ADDR_W-1:0] end_addr,
	input wire logic [flow_ctrl_pkg::ADDR_W-1:0] count,
	output logic at_end,
	output logic take_back,
	output logic [flow_ctrl_pkg::ADDR_W-1:0] count_next
);
	always_comb begin
		at_end = active && (pc == end_addr);
		take_back = at_end && (count != flow_ctrl_pkg::ZERO_WORD);
		count_next = take_back ? count - flow_ctrl_pkg::COUNT_STEP : count;
	end
endmodule : loop_unit
`default_nettype wire

// ### tb/flow_ctrl_assertions.sv
// Purpose: port checks for the flow control block
// Assumes: one clock, async low reset
// Notes: bound to flow_control
`timescale 1ns/1ps
`default_nettype none
module flow_ctrl_checker (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic instr_valid,
	input wire flow_ctrl_pkg::instr_type instr,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [31:0] pc,
	input wire logic fetch_en,
	input wire logic int_allowed,
	input wire logic call_push
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	property p_rd_pc; reg_rd && reg_addr == 4'h4 |=> reg_rdata == $past(pc); endproperty
	a_rd_pc: assert property (p_rd_pc) else $error("pc readback");
	property p_hold; !instr_valid |=> $stable(pc); endproperty
	a_hold: assert property (p_hold) else $error("pc moved idle");
	property p_single; instr_valid && instr.kind == flow_ctrl_pkg::op_single_repeat
		|=> !int_allowed && !fetch_en; endproperty
	a_single: assert property (p_single) else $error("single open");
	property p_block; instr_valid && instr.kind == flow_ctrl_pkg::op_block_repeat
		&& int_allowed |=> int_allowed && fetch_en; endproperty
	a_block: assert property (p_block) else $error("block closed");
	property p_slot; instr_valid && instr.kind == flow_ctrl_pkg::op_delayed_branch
		|=> pc == $past(pc) + 32'h1; endproperty
	a_slot: assert property (p_slot) else $error("branch flushed");
	property p_same; !fetch_en && instr_valid |=> fetch_en ||
		pc == $past(pc); endproperty
	a_same: assert property (p_same) else $error("fetch mismatch");
	property p_status; reg_rd && reg_addr == 4'h3 |=> reg_rdata[3] ==
		$past(int_allowed) && reg_rdata[0] == !$past(int_allowed); endproperty
	a_status: assert property (p_status) else $error("status bits");
	c_single: cover property (!int_allowed);
	c_call: cover property (call_push);
	c_back: cover property (instr_valid ##1 pc < $past(pc));
endmodule : flow_ctrl_checker
bind flow_control flow_ctrl_checker u_chk (.ref_clk(ref_clk), .resetn(resetn),
	.instr_valid(instr_valid), .instr(instr), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc(pc), .fetch_en(fetch_en),
	.int_allowed(int_allowed), .call_push(call_push));
`default_nettype wire

// ### tb/prog_mem.sv
// Purpose: program memory feeding the flow control block
// Assumes: 64 words, word addressed
// Notes: read follows pc at once
`timescale 1ns/1ps
`default_nettype none
module prog_mem (
	input wire logic [31:0] pc,
	output wire flow_ctrl_pkg::instr_type instr
);
	flow_ctrl_pkg::instr_type mem [64];
	function automatic flow_ctrl_pkg::instr_type mk(
		input flow_ctrl_pkg::op_kind_type k, input logic c,
		input logic [7:0] t, input logic w, input logic n);
		return {k, c, 24'h0, t, w, n};
	endfunction : mk
	initial begin
		foreach (mem[i]) mem[i] = '0;
		mem[0] = mk(flow_ctrl_pkg::op_plain, 1'b0, 8'h00, 1'b1, 1'b1);
		mem[1] = mk(flow_ctrl_pkg::op_delayed_branch, 1'b1, 8'h10, 1'b0, 1'b0);
		mem[16] = mk(flow_ctrl_pkg::op_plain, 1'b0, 8'h00, 1'b1, 1'b0);
		mem[17] = mk(flow_ctrl_pkg::op_delayed_branch, 1'b1, 8'h30, 1'b0, 1'b0);
		mem[21] = mk(flow_ctrl_pkg::op_block_repeat, 1'b0, 8'h17, 1'b0, 1'b0);
		mem[24] = mk(flow_ctrl_pkg::op_single_repeat, 1'b0, 8'h00, 1'b0, 1'b0);
		mem[26] = mk(flow_ctrl_pkg::op_plain, 1'b0, 8'h00, 1'b1, 1'b1);
		mem[27] = mk(flow_ctrl_pkg::op_register_call, 1'b1, 8'h28, 1'b0, 1'b0);
	end
	assign instr = mem[pc[5:0]];
endmodule : prog_mem
`default_nettype wire

// ### tb/branch_and_loop_flow_control_test.sv
// Purpose: self-checking bench for the flow control block
// Assumes: program held in prog_mem
// Notes: pc traced after every completed instruction
`timescale 1ns/1ps
`default_nettype none
module branch_and_loop_flow_control_test;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic instr_valid = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, pc, call_return;
	logic fetch_en, int_allowed, call_push;
	flow_ctrl_pkg::instr_type instr;
	int n_fail = 0;
	int comparisons = 0;
	int k = 0;
	logic [7:0] trace [$] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h11,
		8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h16, 8'h17, 8'h16,
		8'h17, 8'h18, 8'h19, 8'h19, 8'h19, 8'h19, 8'h1A, 8'h1B, 8'h28};
	// expected {fetch_en, int_allowed, call_push} per step
	logic [2:0] side [$] = '{3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6,
		3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6,
		3'h6, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h6, 3'h7};
	initial forever #25 ref_clk = ~ref_clk;
	prog_mem u_mem (.pc(pc), .instr(instr));
	flow_control u_dut (.ref_clk(ref_clk), .resetn(resetn),
		.instr_valid(instr_valid), .instr(instr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pc(pc), .fetch_en(fetch_en),
		.int_allowed(int_allowed), .call_push(call_push),
		.call_return(call_return));
	task chk(input logic [31:0] exp, input logic [31:0] act);
		comparisons++;
		if (act !== exp) begin
			n_fail++;
			$display("[ERR] %0t exp %h got %h", $time, exp, act);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(exp, reg_rdata);
		@(posedge ref_clk);
	endtask : rd
	task run(input int n);
		instr_valid <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			if (i == n - 1) begin
				instr_valid <= 1'b0;
			end
			#1 chk(32'(trace[k]), pc);
			chk(32'(side[k]), {29'h0, fetch_en, int_allowed, call_push});
			k++;
		end
		@(posedge ref_clk);
	endtask : run
	task complete_run;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		chk(32'h1, {31'h0, int_allowed});
		wr(flow_ctrl_pkg::OFS_COUNT, 32'h2);
		run(17);
		rd(flow_ctrl_pkg::OFS_STATUS, 32'h8);
		rd(flow_ctrl_pkg::OFS_START, 32'h16);
		rd(flow_ctrl_pkg::OFS_END, 32'h17);
		rd(flow_ctrl_pkg::OFS_COUNT, 32'h0);
		rd(flow_ctrl_pkg::OFS_STATUS, 32'h8);
		rd(flow_ctrl_pkg::OFS_PC, 32'h18);
		rd(4'hF, 32'h0);
		$display("branch and block test done");
		wr(flow_ctrl_pkg::OFS_COUNT, 32'h3);
		run(7);
		chk(32'h1C, call_return);
		$display("single and call test done");
		rd(flow_ctrl_pkg::OFS_START, 32'h19);
		wr(flow_ctrl_pkg::OFS_START, 32'h16);
		wr(flow_ctrl_pkg::OFS_END, 32'h17);
		rd(flow_ctrl_pkg::OFS_END, 32'h17);
		rd(flow_ctrl_pkg::OFS_START, 32'h16);
		rd(flow_ctrl_pkg::OFS_STATUS, 32'h8);
		$display("save and restore test done");
		complete_run();
	end
endmodule : branch_and_loop_flow_control_test
`default_nettype wire
